// ===== bench/duht_far_model.sv
// far side: crystal, serial line and input pins
`timescale 1ns/1ps
`default_nettype none
module duht_far_model (
	// clock
	input wire logic   clk_sys,
	// far-side pins
	output logic       crystal_input,
	output logic       serial_in_a,
	output logic       serial_in_b,
	output logic [6:0] multi_purpose_inputs
);
	initial begin
		crystal_input = 1'b0;
		serial_in_a = 1'b1;
		serial_in_b = 1'b1;
		multi_purpose_inputs = 7'h00;
	end
	// one crystal tick every second edge
	always @(posedge clk_sys) begin
		crystal_input <= ~crystal_input;
	end
	// start, eight bits lsb first, stop; 32 edges a bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			serial_in_a <= f[i];
			repeat (31) @(posedge clk_sys);
		end
	endtask
	task automatic set_pins(input logic [6:0] v);
		@(posedge clk_sys);
		multi_purpose_inputs <= v;
	endtask
endmodule
`default_nettype wire

// ===== bench/duht_monitor.sv
// concurrent checks on the host port and output pins
`timescale 1ns/1ps
`default_nettype none
module duht_monitor (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// host port
	input wire logic       cs_n,
	input wire logic       read_strobe_n,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	// outputs
	input wire logic       int_out,
	input wire logic       int_oe,
	input wire logic [7:3] multi_purpose_outputs,
	input wire logic       tx_clock_a
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence sel_read;
		!cs_n && !read_strobe_n;
	endsequence
	sequence read_held;
		sel_read [*3];
	endsequence
	chk_oe_needs_read: assert property (data_oe |-> !$past(cs_n) && !$past(read_strobe_n))
		else $error("bus driven without read");
	chk_idle_bus_zero: assert property (!data_oe |-> data_out == 8'h00)
		else $error("data not zero when idle");
	chk_read_answer: assert property (read_held |-> data_oe)
		else $error("read not answered");
	chk_read_release: assert property ($rose(read_strobe_n) || $rose(cs_n) |=> !data_oe)
		else $error("bus held after read");
	chk_select_gate: assert property (cs_n |=> !data_oe)
		else $error("bus driven while deselected");
	chk_reset_outputs: assert property ($rose(resetn) |-> multi_purpose_outputs == 5'h1F && !int_oe && !tx_clock_a)
		else $error("outputs not at reset state");
	chk_tx_tick_pulse: assert property (tx_clock_a |=> !tx_clock_a)
		else $error("tick longer than one cycle");
	chk_int_pin_data: assert property (int_out == 1'b0)
		else $error("interrupt pin data high");
endmodule
bind duht_top duht_monitor u_mon (.clk_sys, .resetn, .cs_n, .read_strobe_n, .data_out, .data_oe,
	.int_out, .int_oe, .multi_purpose_outputs, .tx_clock_a);
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the host, timing and input block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk_sys = 1'b0;
	logic       resetn = 1'b0;
	logic       cs_n = 1'b1;
	logic       read_strobe_n = 1'b1;
	logic       write_strobe_n = 1'b1;
	logic [3:0] register_index_lines = 4'h0;
	logic [7:0] data_in = 8'h00;
	logic [7:0] data_out, rd;
	logic       data_oe, int_out, int_oe, tx_clock_a, tx_clock_b;
	logic       crystal_input, serial_in_a, serial_in_b;
	logic [6:0] multi_purpose_inputs, pins;
	logic [7:3] multi_purpose_outputs;
	logic [7:0] sent [6];
	logic [3:0] m;
	int         err_total = 0;
	int         check_count = 0;
	int         n = 0;
	duht_top #(.RX_FIFO_DEPTH(4)) u_dut (.clk_sys, .resetn, .cs_n, .read_strobe_n, .write_strobe_n,
		.register_index_lines, .data_in, .data_out, .data_oe, .crystal_input, .multi_purpose_inputs,
		.serial_in_a, .serial_in_b, .int_out, .int_oe, .multi_purpose_outputs, .tx_clock_a, .tx_clock_b);
	duht_far_model u_far (.clk_sys, .crystal_input, .serial_in_a, .serial_in_b, .multi_purpose_inputs);
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] idx, input logic [7:0] v);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		write_strobe_n <= 1'b0;
		register_index_lines <= idx;
		data_in <= v;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		write_strobe_n <= 1'b1;
		data_in <= ~v;
	endtask
	task automatic reg_rd(input logic [3:0] idx, output logic [7:0] v);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		read_strobe_n <= 1'b0;
		register_index_lines <= idx;
		repeat (3) @(posedge clk_sys);
		#1 v = data_out;
		check8({7'h00, data_oe}, 8'h01);
		@(posedge clk_sys);
		cs_n <= 1'b1;
		read_strobe_n <= 1'b1;
	endtask
	task automatic toggle_wait(input logic [3:0] t);
		pins[3:0] = pins[3:0] ^ t;
		u_far.set_pins(pins);
		repeat (600) @(posedge clk_sys);
	endtask
	task automatic pulse_pin2(input int k);
		repeat (k) begin
			pins[2] = 1'b1;
			u_far.set_pins(pins);
			repeat (2) @(posedge clk_sys);
			pins[2] = 1'b0;
			u_far.set_pins(pins);
			repeat (2) @(posedge clk_sys);
		end
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		final_report();
	end
	initial begin
		void'($urandom(76044));
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		#1 check8({data_oe, int_oe, int_out, multi_purpose_outputs}, 8'h1F);
		repeat (600) @(posedge clk_sys);
		reg_rd(4'h4, rd);
		reg_rd(4'h5, rd);
		check8(rd, 8'h11);
		for (int i = 0; i < 4; i++) begin
			pins = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
			u_far.set_pins(pins);
			repeat (4) @(posedge clk_sys);
			reg_rd(4'hD, rd);
			check8(rd, {1'b0, ~pins});
		end
		pins = 7'h00;
		toggle_wait(4'h0);
		reg_rd(4'h4, rd);
		u_far.set_pins(7'h0F);
		repeat (40) @(posedge clk_sys);
		toggle_wait(4'h0);
		reg_rd(4'h4, rd);
		check8(rd & 8'hF0, 8'h00);
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? 4'hF : 4'($urandom) | 4'h1;
			toggle_wait(m);
			reg_rd(4'h4, rd);
			check8(rd & 8'hF0, {m, 4'h0});
			reg_rd(4'h4, rd);
			check8(rd & 8'hF0, 8'h00);
		end
		reg_wr(4'h4, 8'h0F);
		reg_wr(4'h5, 8'h80);
		@(posedge clk_sys);
		write_strobe_n <= 1'b0;
		data_in <= 8'h00;
		@(posedge clk_sys);
		write_strobe_n <= 1'b1;
		read_strobe_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 check8({7'h00, data_oe}, 8'h00);
		read_strobe_n <= 1'b1;
		toggle_wait(4'h2);
		check8({7'h00, int_oe}, 8'h01);
		reg_rd(4'h5, rd);
		check8(rd, 8'h91);
		reg_rd(4'h4, rd);
		repeat (4) @(posedge clk_sys);
		check8({7'h00, int_oe}, 8'h00);
		reg_wr(4'h5, 8'h00);
		toggle_wait(4'h2);
		reg_rd(4'h5, rd);
		check8(rd, 8'h91);
		check8({7'h00, int_oe}, 8'h00);
		reg_wr(4'h0, 8'h01);
		reg_wr(4'h1, 8'hCC);
		for (int i = 0; i < 6; i++) begin
			sent[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			u_far.send_byte(sent[i]);
		end
		repeat (40) @(posedge clk_sys);
		reg_rd(4'h1, rd);
		check8(rd, 8'h1F);
		reg_rd(4'h1, rd);
		check8(rd & 8'h10, 8'h00);
		reg_rd(4'h5, rd);
		check8(rd & 8'h02, 8'h02);
		for (int i = 0; i < 4; i++) begin
			reg_rd(4'h3, rd);
			check8(rd, sent[i]);
		end
		for (int i = 0; i < 2; i++) begin
			reg_rd(4'h1, rd);
			if (rd[0] === 1'b1) begin
				reg_rd(4'h3, rd);
			end
		end
		reg_rd(4'h1, rd);
		check8(rd & 8'h01, 8'h00);
		reg_wr(4'h8, 8'h01);
		reg_wr(4'h9, 8'h0C);
		repeat (4) @(posedge clk_sys);
		n = 0;
		repeat (64) begin
			@(posedge clk_sys);
			#1 n += int'(tx_clock_b);
		end
		check8(8'(n), 8'h20);
		pins[2] = 1'b0;
		u_far.set_pins(pins);
		reg_wr(4'hD, 8'h04);
		reg_wr(4'h6, 8'h00);
		reg_wr(4'h7, 8'h03);
		reg_rd(4'hE, rd);
		pulse_pin2(2);
		reg_rd(4'hF, rd);
		reg_rd(4'h7, rd);
		check8(rd, 8'h01);
		reg_rd(4'h6, rd);
		check8(rd, 8'h00);
		check8({7'h00, multi_purpose_outputs[3]}, 8'h00);
		reg_rd(4'hE, rd);
		pulse_pin2(5);
		reg_rd(4'h5, rd);
		check8(rd & 8'h08, 8'h08);
		check8({7'h00, multi_purpose_outputs[3]}, 8'h01);
		final_report();
	end
endmodule
`default_nettype wire

// ===== hw/duht_pkg.sv
// shared constants and types for the dual uart host, timing and input block
package duht_pkg;
	// register offsets (same index may differ for read and write)
	localparam logic [3:0] OFS_MODE_ZERO_A    = 4'h0;
	localparam logic [3:0] OFS_STATUS_A       = 4'h1;
	localparam logic [3:0] OFS_CLOCK_SELECT_A = 4'h1;
	localparam logic [3:0] OFS_RX_A           = 4'h3;
	localparam logic [3:0] OFS_INPUT_CHANGE   = 4'h4;
	localparam logic [3:0] OFS_AUX_CONTROL    = 4'h4;
	localparam logic [3:0] OFS_INT_STATUS     = 4'h5;
	localparam logic [3:0] OFS_INT_MASK       = 4'h5;
	localparam logic [3:0] OFS_CT_UPPER       = 4'h6;
	localparam logic [3:0] OFS_CT_LOWER       = 4'h7;
	localparam logic [3:0] OFS_MODE_ZERO_B    = 4'h8;
	localparam logic [3:0] OFS_STATUS_B       = 4'h9;
	localparam logic [3:0] OFS_CLOCK_SELECT_B = 4'h9;
	localparam logic [3:0] OFS_RX_B           = 4'hB;
	localparam logic [3:0] OFS_INPUT_LEVEL    = 4'hD;
	localparam logic [3:0] OFS_OUTPUT_CONFIG  = 4'hD;
	localparam logic [3:0] OFS_CT_START       = 4'hE;
	localparam logic [3:0] OFS_CT_STOP        = 4'hF;
	// field positions
	localparam int ACR_CLK_SET   = 7;
	localparam int ACR_CT_TIMER  = 6;
	localparam int ACR_CT_DIV16  = 4;
	localparam int MR0_EXT_LO    = 0;
	localparam int MR0_EXT_HI    = 2;
	localparam int MR0_PAR_EN    = 3;
	localparam int MR0_PAR_ODD   = 1;
	localparam int OPCR_CT_OUT   = 2;
	localparam int OPCR_RXA_RDY  = 4;
	localparam int OPCR_RXB_RDY  = 5;
	// clock select codes and source fields
	localparam logic [3:0] CSR_CT      = 4'hD;
	localparam logic [3:0] CSR_EXT16   = 4'hE;
	localparam logic [2:0] ACR_SRC_PIN = 3'h0;
	// crystal divisions
	localparam int XTAL_HZ      = 3686400;
	localparam int CHANGE_RATE_HZ = 38400;
	localparam logic [6:0] CHANGE_DIV = 7'(XTAL_HZ / CHANGE_RATE_HZ);
	localparam logic [3:0] CT_PRESCALE = 4'hF;
	// receiver sample points in 16x ticks
	localparam logic [3:0] RX_START_CHECK = 4'h7;
	localparam logic [3:0] RX_BIT_LAST    = 4'hF;
	localparam logic [2:0] RX_DATA_LAST   = 3'h7;
	localparam logic [7:0] RESET_OUTPUTS  = 8'hFF;

	typedef struct packed {
		logic       brk;
		logic       frame_err;
		logic       par_err;
		logic [7:0] data;
	} duht_rx_word_t;

	// 16x divisor in crystal cycles per clock-select code, rate set and extension
	function automatic logic [12:0] duht_baud_div(input logic [3:0] nib, input logic set, input logic ext);
		logic [12:0] d;
		d = 13'h0018;
		case (nib)
			4'h0: d = set ? 13'h0C00 : 13'h1200;
			4'h1: d = 13'h082E;
			4'h2: d = 13'h06B1;
			4'h3: d = set ? 13'h0600 : 13'h0480;
			4'h4: d = 13'h0300;
			4'h5: d = 13'h0180;
			4'h6: d = 13'h00C0;
			4'h7: d = set ? 13'h0073 : 13'h00DB;
			4'h8: d = 13'h0060;
			4'h9: d = set ? 13'h0060 : 13'h0030;
			4'hA: d = set ? 13'h0080 : 13'h0020;
			4'hB: d = 13'h0018;
			4'hC: d = ext ? 13'h0001 : (set ? 13'h000C : 13'h0006);
			default: d = 13'h0018;
		endcase
		return d;
	endfunction
endpackage

// ===== hw/duht_top.sv
// host port, clock selection, counter/timer, receivers, interrupts and input detectors
`timescale 1ns/1ps
`default_nettype none

module duht_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module duht_rx (
	// clock and reset
	input  wire logic           clk_sys,
	input  wire logic           resetn,
	// line side
	input  wire logic           tick16,
	input  wire logic           serial_in,
	input  wire logic           par_en,
	input  wire logic           par_odd,
	// character output
	output logic                out_valid,
	input  wire logic           out_ready,
	output duht_pkg::duht_rx_word_t out_word,
	output logic                overrun
);
	typedef enum logic [2:0] {
		RX_IDLE  = 3'h0,
		RX_START = 3'h1,
		RX_DATA  = 3'h3,
		RX_PAR   = 3'h2,
		RX_STOP  = 3'h6
	} duht_rx_state_t;

	duht_rx_state_t state_q;
	logic [3:0]     sub_q;
	logic [2:0]     bit_q;
	logic [7:0]     sh_q;
	logic           perr_q;
	logic           pbit_q;
	logic           sample;

	assign sample = tick16 & (sub_q == duht_pkg::RX_BIT_LAST);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= RX_IDLE;
			sub_q   <= '0;
			bit_q   <= '0;
			sh_q    <= '0;
			perr_q  <= 1'b0;
			pbit_q  <= 1'b0;
		end else begin
			if (tick16) begin
				sub_q <= sub_q + 1'b1;
			end
			unique case (state_q)
				RX_IDLE: begin
					sub_q <= '0;
					if (tick16 && !serial_in) begin
						state_q <= RX_START;
					end
				end
				RX_START: begin
					if (tick16 && sub_q == duht_pkg::RX_START_CHECK - 1'b1) begin
						sub_q  <= '0;
						bit_q  <= '0;
						pbit_q <= 1'b0;
						perr_q <= 1'b0;
						state_q <= serial_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (sample) begin
						sh_q  <= {serial_in, sh_q[7:1]};
						bit_q <= bit_q + 1'b1;
						if (bit_q == duht_pkg::RX_DATA_LAST) begin
							state_q <= par_en ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (sample) begin
						pbit_q  <= serial_in;
						perr_q  <= (^{sh_q, serial_in}) != par_odd;
						state_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (sample) begin
						state_q <= RX_IDLE;
					end
				end
				default: begin
					state_q <= RX_IDLE;
				end
			endcase
		end
	end

	// hand-over of a finished character; a full holding stage means overrun
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_word  <= '0;
			overrun   <= 1'b0;
		end else begin
			overrun <= 1'b0;
			if (out_valid && out_ready) begin
				out_valid <= 1'b0;
			end
			if (state_q == RX_STOP && sample) begin
				if (out_valid && !out_ready) begin
					overrun <= 1'b1;
				end else begin
					out_valid          <= 1'b1;
					out_word.data      <= sh_q;
					out_word.par_err   <= perr_q;
					out_word.frame_err <= ~serial_in;
					out_word.brk       <= ~serial_in & ~pbit_q & (sh_q == '0);
				end
			end
		end
	end
endmodule

module duht_top #(
	parameter int RX_FIFO_DEPTH = 4
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// host port
	input  wire logic       cs_n,
	input  wire logic       read_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic [3:0] register_index_lines,
	input  wire logic [7:0] data_in,
	output logic [7:0]      data_out,
	output logic            data_oe,
	// timing and far-side pins
	input  wire logic       crystal_input,
	input  wire logic [6:0] multi_purpose_inputs,
	input  wire logic       serial_in_a,
	input  wire logic       serial_in_b,
	// outputs
	output logic            int_out,
	output logic            int_oe,
	output logic [7:3]      multi_purpose_outputs,
	output logic            tx_clock_a,
	output logic            tx_clock_b
);
	localparam int RW = $bits(duht_pkg::duht_rx_word_t);

	logic [7:0]  mode_zero_a_q, mode_zero_b_q, clock_select_a_q, clock_select_b_q;
	logic [7:0]  auxiliary_control_q, interrupt_mask_q, output_config_q, ct_upper_q, ct_lower_q;
	logic        wr_act_q, rd_act_q;
	logic [3:0]  rd_idx_q;
	logic        wr_act, rd_act, wr_go, rd_end;
	logic [7:0]  rd_mux;
	logic        xtal_q;
	logic [6:0]  mpi_q;
	logic        xtal_tick;
	logic [6:0]  pin_rise;
	logic [3:0]  pre_q;
	logic [15:0] ct_cnt_q;
	logic        ct_run_q, ct_out_q, ct_tick_q, ct_ready_q;
	logic        ct_src;
	logic [6:0]  chg_div_q;
	logic [3:0]  chg_s1_q, chg_lvl_q, chg_flag_q, chg_set;
	logic [3:0]  sel_tick_q;
	logic [3:0]  sel_nib [4];
	logic [3:0]  sel_ext;
	logic [1:0]  rx_valid, rx_ready, rx_ovr, ff_valid, ff_ready, ff_full_n, ovr_q, brk_q;
	duht_pkg::duht_rx_word_t rx_word [2];
	duht_pkg::duht_rx_word_t ff_word [2];
	logic [7:0]  interrupt_status;
	logic [7:0]  status [2];

	// host strobes, gated by select
	assign wr_act    = ~cs_n & ~write_strobe_n;
	assign rd_act    = ~cs_n & ~read_strobe_n;
	assign wr_go     = wr_act & ~wr_act_q;
	assign rd_end    = rd_act_q & ~rd_act;
	assign xtal_tick = crystal_input & ~xtal_q;
	assign pin_rise  = multi_purpose_inputs & ~mpi_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			rd_idx_q <= '0;
			xtal_q   <= 1'b0;
			mpi_q    <= '0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			xtal_q   <= crystal_input;
			mpi_q    <= multi_purpose_inputs;
			if (rd_act && !rd_act_q) begin
				rd_idx_q <= register_index_lines;
			end
		end
	end

	// writable registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_zero_a_q       <= '0;
			mode_zero_b_q       <= '0;
			clock_select_a_q    <= '0;
			clock_select_b_q    <= '0;
			auxiliary_control_q <= '0;
			interrupt_mask_q    <= '0;
			output_config_q     <= '0;
			ct_upper_q          <= '0;
			ct_lower_q          <= '0;
		end else if (wr_go) begin
			case (register_index_lines)
				duht_pkg::OFS_MODE_ZERO_A:    mode_zero_a_q       <= data_in;
				duht_pkg::OFS_CLOCK_SELECT_A: clock_select_a_q    <= data_in;
				duht_pkg::OFS_AUX_CONTROL:    auxiliary_control_q <= data_in;
				duht_pkg::OFS_INT_MASK:       interrupt_mask_q    <= data_in;
				duht_pkg::OFS_CT_UPPER:       ct_upper_q          <= data_in;
				duht_pkg::OFS_CT_LOWER:       ct_lower_q          <= data_in;
				duht_pkg::OFS_MODE_ZERO_B:    mode_zero_b_q       <= data_in;
				duht_pkg::OFS_CLOCK_SELECT_B: clock_select_b_q    <= data_in;
				duht_pkg::OFS_OUTPUT_CONFIG:  output_config_q     <= data_in;
				default: ;
			endcase
		end
	end

	// counter/timer source and prescale
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pre_q <= '0;
		end else if (xtal_tick) begin
			pre_q <= pre_q + 1'b1;
		end
	end

	always_comb begin
		if (auxiliary_control_q[6:4] == duht_pkg::ACR_SRC_PIN) begin
			ct_src = pin_rise[2];
		end else if (auxiliary_control_q[duht_pkg::ACR_CT_DIV16]) begin
			ct_src = xtal_tick & (pre_q == duht_pkg::CT_PRESCALE);
		end else begin
			ct_src = xtal_tick;
		end
	end

	// counter/timer
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ct_cnt_q   <= '0;
			ct_run_q   <= 1'b0;
			ct_out_q   <= 1'b0;
			ct_tick_q  <= 1'b0;
			ct_ready_q <= 1'b0;
		end else begin
			ct_tick_q <= 1'b0;
			if (rd_act && !rd_act_q && register_index_lines == duht_pkg::OFS_CT_START) begin
				ct_run_q <= 1'b1;
				ct_cnt_q <= {ct_upper_q, ct_lower_q};
			end else if (rd_act && !rd_act_q && register_index_lines == duht_pkg::OFS_CT_STOP) begin
				ct_run_q   <= 1'b0;
				ct_ready_q <= 1'b0;
			end else if (ct_src && (ct_run_q || auxiliary_control_q[duht_pkg::ACR_CT_TIMER])) begin
				if (ct_cnt_q == '0) begin
					ct_ready_q <= 1'b1;
					ct_out_q   <= ~ct_out_q;
					ct_tick_q  <= ~ct_out_q;
					ct_cnt_q   <= auxiliary_control_q[duht_pkg::ACR_CT_TIMER] ? {ct_upper_q, ct_lower_q} : '1;
				end else begin
					ct_cnt_q <= ct_cnt_q - 1'b1;
				end
			end
		end
	end

	// channel clock selectors: txa, rxa, txb, rxb
	always_comb begin
		sel_nib[0] = clock_select_a_q[3:0];
		sel_nib[1] = clock_select_a_q[7:4];
		sel_nib[2] = clock_select_b_q[3:0];
		sel_nib[3] = clock_select_b_q[7:4];
		sel_ext[0] = mode_zero_a_q[duht_pkg::MR0_EXT_LO] | mode_zero_a_q[duht_pkg::MR0_EXT_HI];
		sel_ext[1] = sel_ext[0];
		sel_ext[2] = mode_zero_b_q[duht_pkg::MR0_EXT_LO] | mode_zero_b_q[duht_pkg::MR0_EXT_HI];
		sel_ext[3] = sel_ext[2];
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sel
			logic [12:0] cnt_q;
			logic [12:0] div;
			assign div = duht_pkg::duht_baud_div(sel_nib[g], auxiliary_control_q[duht_pkg::ACR_CLK_SET], sel_ext[g]);
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					cnt_q         <= '0;
					sel_tick_q[g] <= 1'b0;
				end else begin
					sel_tick_q[g] <= 1'b0;
					if (sel_nib[g] == duht_pkg::CSR_CT) begin
						sel_tick_q[g] <= ct_tick_q;
					end else if (sel_nib[g] >= duht_pkg::CSR_EXT16) begin
						sel_tick_q[g] <= pin_rise[3+g];
					end else if (xtal_tick) begin
						if (cnt_q >= div - 1'b1) begin
							cnt_q         <= '0;
							sel_tick_q[g] <= 1'b1;
						end else begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	// receivers and their buffers
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic [7:0] mr0;
			assign mr0 = (g == 0) ? mode_zero_a_q : mode_zero_b_q;
			duht_rx u_rx (
				.clk_sys   (clk_sys),
				.resetn    (resetn),
				.tick16    (sel_tick_q[2*g+1]),
				.serial_in ((g == 0) ? serial_in_a : serial_in_b),
				.par_en    (mr0[duht_pkg::MR0_PAR_EN]),
				.par_odd   (mr0[duht_pkg::MR0_PAR_ODD]),
				.out_valid (rx_valid[g]),
				.out_ready (rx_ready[g]),
				.out_word  (rx_word[g]),
				.overrun   (rx_ovr[g])
			);
			duht_fifo #(
				.WIDTH (RW),
				.DEPTH (RX_FIFO_DEPTH)
			) u_fifo (
				.clk_sys   (clk_sys),
				.resetn    (resetn),
				.in_valid  (rx_valid[g]),
				.in_ready  (rx_ready[g]),
				.in_data   (rx_word[g]),
				.out_valid (ff_valid[g]),
				.out_ready (ff_ready[g]),
				.out_data  (ff_word[g])
			);
			assign ff_ready[g]  = rd_end & (rd_idx_q == ((g == 0) ? duht_pkg::OFS_RX_A : duht_pkg::OFS_RX_B));
			assign ff_full_n[g] = rx_ready[g];
			assign status[g]    = {brk_q[g], ff_word[g].frame_err & ff_valid[g], ff_word[g].par_err & ff_valid[g],
				ovr_q[g], 1'b1, 1'b1, ~ff_full_n[g], ff_valid[g]};
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					ovr_q[g] <= 1'b0;
					brk_q[g] <= 1'b0;
				end else begin
					if (rd_end && rd_idx_q == ((g == 0) ? duht_pkg::OFS_STATUS_A : duht_pkg::OFS_STATUS_B)) begin
						ovr_q[g] <= rx_ovr[g];
						brk_q[g] <= rx_valid[g] & rx_ready[g] & rx_word[g].brk;
					end else begin
						ovr_q[g] <= ovr_q[g] | rx_ovr[g];
						brk_q[g] <= brk_q[g] | (rx_valid[g] & rx_ready[g] & rx_word[g].brk);
					end
				end
			end
		end
	endgenerate

	// change-of-state detectors
	assign chg_set = (chg_div_q == duht_pkg::CHANGE_DIV - 1'b1 && xtal_tick)
		? ((multi_purpose_inputs[3:0] ~^ chg_s1_q) & (multi_purpose_inputs[3:0] ^ chg_lvl_q)) : '0;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			chg_div_q  <= '0;
			chg_s1_q   <= '0;
			chg_lvl_q  <= '0;
			chg_flag_q <= '0;
		end else begin
			if (xtal_tick) begin
				chg_div_q <= (chg_div_q == duht_pkg::CHANGE_DIV - 1'b1) ? '0 : chg_div_q + 1'b1;
				if (chg_div_q == duht_pkg::CHANGE_DIV - 1'b1) begin
					chg_s1_q <= multi_purpose_inputs[3:0];
				end
			end
			chg_lvl_q <= chg_lvl_q ^ chg_set;
			if (rd_end && rd_idx_q == duht_pkg::OFS_INPUT_CHANGE) begin
				chg_flag_q <= chg_set;
			end else begin
				chg_flag_q <= chg_flag_q | chg_set;
			end
		end
	end

	// interrupt status, six events and two bits tied high
	assign interrupt_status = {|(chg_flag_q & auxiliary_control_q[3:0]), brk_q[1], ff_valid[1], 1'b1,
		ct_ready_q, brk_q[0], ff_valid[0], 1'b1};

	// read multiplexer
	always_comb begin
		case (rd_idx_q)
			duht_pkg::OFS_STATUS_A:     rd_mux = status[0];
			duht_pkg::OFS_RX_A:         rd_mux = ff_word[0].data;
			duht_pkg::OFS_INPUT_CHANGE: rd_mux = {chg_flag_q, chg_lvl_q};
			duht_pkg::OFS_INT_STATUS:   rd_mux = interrupt_status;
			duht_pkg::OFS_CT_UPPER:     rd_mux = ct_cnt_q[15:8];
			duht_pkg::OFS_CT_LOWER:     rd_mux = ct_cnt_q[7:0];
			duht_pkg::OFS_STATUS_B:     rd_mux = status[1];
			duht_pkg::OFS_RX_B:         rd_mux = ff_word[1].data;
			duht_pkg::OFS_INPUT_LEVEL:  rd_mux = {1'b0, ~multi_purpose_inputs};
			default:                    rd_mux = '0;
		endcase
	end

	// registered outputs
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			data_out              <= '0;
			data_oe               <= 1'b0;
			int_out               <= 1'b0;
			int_oe                <= 1'b0;
			multi_purpose_outputs <= duht_pkg::RESET_OUTPUTS[7:3];
			tx_clock_a            <= 1'b0;
			tx_clock_b            <= 1'b0;
		end else begin
			data_oe    <= rd_act & rd_act_q;
			data_out   <= (rd_act & rd_act_q) ? rd_mux : '0;
			int_out    <= 1'b0;
			int_oe     <= |(interrupt_status & interrupt_mask_q);
			tx_clock_a <= sel_tick_q[0];
			tx_clock_b <= sel_tick_q[2];
			multi_purpose_outputs[3] <= output_config_q[duht_pkg::OPCR_CT_OUT] ? ct_out_q : 1'b1;
			multi_purpose_outputs[4] <= output_config_q[duht_pkg::OPCR_RXA_RDY] ? ~ff_valid[0] : 1'b1;
			multi_purpose_outputs[5] <= output_config_q[duht_pkg::OPCR_RXB_RDY] ? ~ff_valid[1] : 1'b1;
			multi_purpose_outputs[6] <= 1'b1;
			multi_purpose_outputs[7] <= 1'b1;
		end
	end
endmodule

`default_nettype wire
